// ===== hdl/rst_sel_pkg.sv
// Package: constants and types for the reset indication selector
package rst_sel_pkg;
  // Levels of the active-low reset indication pin
  localparam logic IND_ASSERTED = 1'b0;
  localparam logic IND_NEGATED = 1'b1;
  // Synchroniser depth for the external reset request
  localparam int SYNC_STAGES = 2;
  // Reset values
  localparam logic RST_SYNC_VAL = 1'b0;
  localparam logic RST_IND_VAL = IND_ASSERTED;

  typedef enum logic [1:0]
  {
    SRC_RESET,
    SRC_FORCE,
    SRC_MIRROR,
    SRC_IDLE
  } ind_source_t;
endpackage

// ===== hdl/rst_sel_if.sv
// Interface: external reset request between selector and its synchroniser
`timescale 1ns/100ps
`default_nettype none
interface rst_sel_if;
  logic req_raw;
  logic stop_mode;
  logic req_out;
  modport sync_side
  (
    input req_raw,
    input stop_mode,
    output req_out
  );
  modport top_side
  (
    output req_raw,
    output stop_mode,
    input req_out
  );
endinterface
`default_nettype wire

// ===== hdl/ext_reset_sync.sv
// Synchroniser for the external reset request with stop-mode bypass
`timescale 1ns/100ps
`default_nettype none
module ext_reset_sync
(
  input wire logic core_clk,
  input wire logic srst,
  rst_sel_if.sync_side port
);
  import rst_sel_pkg::*;

  logic stage1_q;
  logic stage1_d;
  logic stage2_q;
  logic stage2_d;

  always_comb
  begin
    stage1_d = port.req_raw;
    stage2_d = stage1_q;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stage1_q <= RST_SYNC_VAL;
      stage2_q <= RST_SYNC_VAL;
    end
    else
    begin
      stage1_q <= stage1_d;
      stage2_q <= stage2_d;
    end
  end

  // Clocks stop in stop mode, so the raw level must pass straight through
  assign port.req_out = port.stop_mode ? port.req_raw : stage2_q;

  sync_path_a: assert property (@(posedge core_clk) disable iff (srst)
    !port.stop_mode && $past(port.stop_mode) == 1'b0
      && !$past(port.stop_mode, 2)
      && !$past(srst) && !$past(srst, 2)
      |-> port.req_out == $past(port.req_raw, 2))
    else $error("synchronised reset request wrong");
  stop_bypass_a: assert property (@(posedge core_clk) disable iff (srst)
    port.stop_mode |-> port.req_out == port.req_raw)
    else $error("stop mode bypass broken");
endmodule
`default_nettype wire

// ===== hdl/reset_out_signal_select.sv
// Top: selects the source of the active-low reset indication pin
`timescale 1ns/100ps
`default_nettype none
module reset_out_signal_select
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic force_reset_indication_bit,
  input wire logic mirror_interrupt_bit,
  input wire logic irq_pending,
  input wire logic pll_test_mode,
  input wire logic ext_reset_req_n,
  input wire logic stop_mode,
  output logic ext_reset_req_sync_n,
  output logic reset_indication_out_n_o,
  output logic reset_indication_out_n_oe,
  output rst_sel_pkg::ind_source_t ind_source
);
  import rst_sel_pkg::*;

  rst_sel_if sync_link ();

  logic ind_q;
  logic ind_d;
  ind_source_t src_q;
  ind_source_t src_d;

  // ------------------------------------------------------------
  // External reset request path
  // ------------------------------------------------------------
  assign sync_link.req_raw = ext_reset_req_n;
  assign sync_link.stop_mode = stop_mode;
  assign ext_reset_req_sync_n = sync_link.req_out;

  ext_reset_sync u_sync
  (
    .core_clk(core_clk),
    .srst(srst),
    .port(sync_link.sync_side)
  );

  // ------------------------------------------------------------
  // Source priority
  // ------------------------------------------------------------
  always_comb
  begin
    if (force_reset_indication_bit)
    begin
      src_d = SRC_FORCE;
      ind_d = IND_ASSERTED;
    end
    else if (mirror_interrupt_bit)
    begin
      src_d = SRC_MIRROR;
      ind_d = irq_pending ? IND_ASSERTED : IND_NEGATED;
    end
    else
    begin
      src_d = SRC_IDLE;
      ind_d = IND_NEGATED;
    end
  end

  // Reset wins over the force and mirror bits, not over pll_test_mode; register avoids mux glitches
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      ind_q <= RST_IND_VAL;
      src_q <= SRC_RESET;
    end
    else
    begin
      ind_q <= ind_d;
      src_q <= src_d;
    end
  end

  assign reset_indication_out_n_o = ind_q;
  // Pin floats in PLL test; board pull-up decides its level there
  assign reset_indication_out_n_oe = !pll_test_mode;
  assign ind_source = src_q;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  reset_asserts_a: assert property (@(posedge core_clk)
    srst |=> reset_indication_out_n_o == 1'b0
      && ind_source == SRC_RESET)
    else $error("reset did not assert indication");
  force_holds_a: assert property (@(posedge core_clk) disable iff (srst)
    $past(force_reset_indication_bit) && !$past(srst)
      |-> reset_indication_out_n_o == 1'b0)
    else $error("force bit did not assert indication");
  mirror_follows_a: assert property (@(posedge core_clk) disable iff (srst)
    !$past(force_reset_indication_bit) && $past(mirror_interrupt_bit)
      && !$past(srst)
      |-> reset_indication_out_n_o == !$past(irq_pending))
    else $error("indication not following interrupt");
  idle_negated_a: assert property (@(posedge core_clk) disable iff (srst)
    !$past(force_reset_indication_bit) && !$past(mirror_interrupt_bit)
      && !$past(srst)
      |-> reset_indication_out_n_o == 1'b1)
    else $error("indication not negated when idle");
  force_release_a: assert property (@(posedge core_clk) disable iff (srst)
    $fell(force_reset_indication_bit) && !mirror_interrupt_bit
      |=> reset_indication_out_n_o == 1'b1)
    else $error("indication stuck after force cleared");
  pll_float_a: assert property (@(posedge core_clk)
    pll_test_mode |-> !reset_indication_out_n_oe)
    else $error("pin driven in PLL test");
  drive_normal_a: assert property (@(posedge core_clk)
    !pll_test_mode |-> reset_indication_out_n_oe)
    else $error("pin not driven outside PLL test");
  one_cycle_a: assert property (@(posedge core_clk) disable iff (srst)
    !$past(srst) && !$past(force_reset_indication_bit)
      && !$past(mirror_interrupt_bit) && force_reset_indication_bit
      |-> reset_indication_out_n_o == 1'b1)
    else $error("registered indication timing wrong");

  force_seen_c: cover property (@(posedge core_clk) disable iff (srst)
    ind_source == SRC_FORCE);
  mirror_seen_c: cover property (@(posedge core_clk) disable iff (srst)
    ind_source == SRC_MIRROR && reset_indication_out_n_o == 1'b0);
  idle_seen_c: cover property (@(posedge core_clk) disable iff (srst)
    ind_source == SRC_IDLE);
  reset_seen_c: cover property (@(posedge core_clk)
    srst ##1 !srst);
  stop_seen_c: cover property (@(posedge core_clk) disable iff (srst)
    stop_mode && !ext_reset_req_n);
endmodule
`default_nettype wire

// ===== bench/board_model.sv
// Board model: drives configuration data while the indication is low
`timescale 1ns/100ps
`default_nettype none
module board_model
(
  input wire logic core_clk,
  input wire logic ind_n,
  output logic [3:0] cfg = 4'h0
);
  // Released bus floats to its pull-up level
  // Forced or mirrored lows also trigger a drive
  always @(posedge core_clk)
    cfg <= !ind_n ? 4'h5 : 4'hf;
endmodule
`default_nettype wire

// ===== bench/tb.sv
// Testbench for the reset indication selector
`timescale 1ns/100ps
`default_nettype none
module tb;
  import rst_sel_pkg::*;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic frc = 1'b0;
  logic mir = 1'b0;
  logic irq = 1'b0;
  logic pll = 1'b0;
  logic ext_n = 1'b1;
  logic stop = 1'b0;
  logic sync_n;
  logic ind_n;
  logic oe;
  ind_source_t src;
  logic [3:0] cfg;
  int bad_count = 0;
  int n_compared = 0;
  reset_out_signal_select dut
  (
    .core_clk(core_clk), .srst(srst), .force_reset_indication_bit(frc),
    .mirror_interrupt_bit(mir), .irq_pending(irq), .pll_test_mode(pll),
    .ext_reset_req_n(ext_n), .stop_mode(stop),
    .ext_reset_req_sync_n(sync_n), .reset_indication_out_n_o(ind_n),
    .reset_indication_out_n_oe(oe), .ind_source(src)
  );
  board_model board
  (
    .core_clk(core_clk), .ind_n(ind_n), .cfg(cfg)
  );
  initial
  begin
    forever #25 core_clk = ~core_clk;
  end
  task step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task check(input string nm, input logic [3:0] seen, input logic [3:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task end_of_test;
    if (bad_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Priority walk: force beats mirror, mirror follows irq
  task t_prio;
    {frc, mir, irq} = 3'h6;
    step(6);
    check("src", src, SRC_FORCE);
    check("ind", ind_n, IND_ASSERTED);
    check("cfg", cfg, 4'h5);
    frc = 1'b0;
    #1;
    check("ind", ind_n, IND_ASSERTED);
    step(1);
    check("ind", ind_n, IND_NEGATED);
    irq = 1'b1;
    step(1);
    check("ind", ind_n, IND_ASSERTED);
    mir = 1'b0;
    step(1);
    check("src", src, SRC_IDLE);
    check("ind", ind_n, 2'h1);
  endtask
  task t_sync;
    ext_n = 1'b0;
    step(1);
    check("sync", sync_n, 2'h1);
    check("cfg", cfg, 4'hf);
    step(1);
    check("sync", sync_n, 2'h0);
    stop = 1'b1;
    ext_n = 1'b1;
    #1;
    check("sync", sync_n, 2'h1);
    ext_n = 1'b0;
    step(1);
    check("sync", sync_n, 2'h0);
    ext_n = 1'b1;
    stop = 1'b0;
    step(2);
    check("sync", sync_n, 2'h1);
  endtask
  task t_pll;
    pll = 1'b1;
    #1;
    check("oe", oe, 2'h0);
    pll = 1'b0;
    #1;
    check("oe", oe, 2'h1);
  endtask
  // Reset mid-run overrides force and mirror
  task t_midrst;
    {srst, frc, mir} = 3'h7;
    step(1);
    check("src", src, SRC_RESET);
    check("ind", ind_n, IND_ASSERTED);
    {srst, frc} = 2'h0;
    step(1);
    check("src", src, SRC_MIRROR);
    check("ind", ind_n, IND_ASSERTED);
  endtask
  initial
  begin
    step(10);
    check("ind", ind_n, IND_ASSERTED);
    srst = 1'b0;
    t_prio;
    t_sync;
    t_pll;
    t_midrst;
    end_of_test;
  end
  initial
  begin
    repeat (400) @(posedge core_clk);
    bad_count++;
    end_of_test;
  end
endmodule
`default_nettype wire
